//--- core/rsfr_pkg.sv
// constants and types shared by the special-function register block
package rsfr_pkg;
    // ------------------------------------------------------------
    // register map (index = printed offset, byte address = index * 4)
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_OPT = 8'h10;
    localparam logic [7:0] IDX_MIRROR = 8'h11;
    localparam logic [7:0] IDX_FIFO = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_OPT = {IDX_OPT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MIRROR = {IDX_MIRROR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FIFO = {IDX_FIFO, 2'b00};
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [7:0] FIFO_RESET = 8'h00;
    localparam logic [7:0] OPT_WMASK = 8'h3F;
    localparam logic [7:0] FIFO_WMASK = 8'h0F;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OPT_PAR_DIS = 5;
    localparam int OPT_SLOT = 4;
    localparam int OPT_DIRECT = 3;
    localparam int OPT_SHORT_RX = 2;
    localparam int OPT_FRAMING = 1;
    localparam int OPT_COL = 0;
    localparam int MIRROR_RXS = 0;
    localparam int FIFO_HI_LSB = 2;
    localparam int FIFO_LO_LSB = 0;
    // ------------------------------------------------------------
    // fifo watermark levels in bytes
    // ------------------------------------------------------------
    localparam logic [7:0] HI_LVL0 = 8'h7C;
    localparam logic [7:0] HI_LVL1 = 8'h78;
    localparam logic [7:0] HI_LVL2 = 8'h70;
    localparam logic [7:0] HI_LVL3 = 8'h60;
    localparam logic [7:0] LO_LVL0 = 8'h04;
    localparam logic [7:0] LO_LVL1 = 8'h08;
    localparam logic [7:0] LO_LVL2 = 8'h10;
    localparam logic [7:0] LO_LVL3 = 8'h20;
    // ------------------------------------------------------------
    // protocol constants
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_CL1 = 8'h93;
    localparam logic [7:0] SEL_CL2 = 8'h95;
    localparam logic [7:0] SEL_CL3 = 8'h97;
    localparam logic [2:0] COL_PULSES_LONG = 3'h7;
    localparam logic [2:0] COL_PULSES_SHORT = 3'h6;
    // ------------------------------------------------------------
    // timing: slot grid in hundredths of a microsecond
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SLOT_SHORT_CUS = 1888;
    localparam int SLOT_LONG_CUS = 3777;
    localparam int SLOT_SHORT_CYC = SLOT_SHORT_CUS * 10000 / CLK_PERIOD_PS;
    localparam int SLOT_LONG_CYC = SLOT_LONG_CUS * 10000 / CLK_PERIOD_PS;
    localparam int SLOT_W = 14;
    // ------------------------------------------------------------
    // bus answers and states
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {RSFR_SEL_NONE, RSFR_SEL_OPT, RSFR_SEL_MIRROR, RSFR_SEL_FIFO} rsfr_sel_e;
    typedef enum {RSFR_RX_IDLE, RSFR_RX_BUSY} rsfr_rx_e;
endpackage

//--- core/rsfr_fifo_level.sv
// fifo watermark compare for receive fill and transmit drain
`timescale 1ns/1ps
module rsfr_fifo_level #(
    parameter int CNT_W = 8
) (
    input wire logic aclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [1:0] hi_code,
    input wire logic [1:0] lo_code,
    input wire logic [CNT_W-1:0] fifo_count,
    input wire logic rx_active,
    input wire logic tx_active,
    output logic fifo_high_r,
    output logic fifo_low_r
);
    initial begin
        if (CNT_W < 8) $error("fifo count too narrow for watermark levels");
    end

    function automatic logic [7:0] hi_level(input logic [1:0] code);
        case (code)
            2'h0: hi_level = rsfr_pkg::HI_LVL0;
            2'h1: hi_level = rsfr_pkg::HI_LVL1;
            2'h2: hi_level = rsfr_pkg::HI_LVL2;
            default: hi_level = rsfr_pkg::HI_LVL3;
        endcase
    endfunction

    function automatic logic [7:0] lo_level(input logic [1:0] code);
        case (code)
            2'h0: lo_level = rsfr_pkg::LO_LVL0;
            2'h1: lo_level = rsfr_pkg::LO_LVL1;
            2'h2: lo_level = rsfr_pkg::LO_LVL2;
            default: lo_level = rsfr_pkg::LO_LVL3;
        endcase
    endfunction

    always_ff @(posedge aclk) begin
        if (srst) begin
            fifo_high_r <= 1'b0;
            fifo_low_r <= 1'b0;
        end else if (ce) begin
            fifo_high_r <= rx_active && (fifo_count >= CNT_W'(hi_level(hi_code)));
            fifo_low_r <= tx_active && (fifo_count <= CNT_W'(lo_level(lo_code)));
        end
    end

    chk_high_watermark: assert property (@(posedge aclk) disable iff (srst)
        ce && rx_active && fifo_count >= CNT_W'(hi_level(hi_code)) |=> fifo_high_r)
        else $error("high watermark not raised");
    chk_low_watermark: assert property (@(posedge aclk) disable iff (srst)
        ce && tx_active && fifo_count <= CNT_W'(lo_level(lo_code)) |=> fifo_low_r)
        else $error("low watermark not raised");
endmodule

//--- core/rsfr_regs.sv
// special-function and fifo threshold registers with axi4-lite slave
`timescale 1ns/1ps
module rsfr_regs #(
    parameter int SLOT_SHORT = rsfr_pkg::SLOT_SHORT_CYC,
    parameter int SLOT_LONG = rsfr_pkg::SLOT_LONG_CYC,
    parameter int CNT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic chip_en,
    input wire logic [rsfr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rsfr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_sof_seen,
    input wire logic rx_done,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic [CNT_W-1:0] fifo_count,
    input wire logic parity_err_raw,
    input wire logic coll_window_start,
    input wire logic subcarrier_pulse,
    input wire logic rx_nibble_end,
    input wire logic tx_byte_first,
    input wire logic [7:0] tx_byte,
    input wire logic bit_tick,
    input wire logic fifo_tx_bit,
    input wire logic direct_tx_bit,
    output logic parity_err_r,
    output logic [rsfr_pkg::SLOT_W-1:0] slot_step_cyc_r,
    output logic enc_bit_r,
    output logic enc_valid_r,
    output logic fifo_tx_pop_r,
    output logic short_frame_ok_r,
    output logic anticoll_broken_r,
    output logic collision_err_r,
    output logic rx_start_r,
    output logic rx_done_irq_r,
    output logic fifo_high_irq_r,
    output logic fifo_low_irq_r
);
    initial begin
        if (SLOT_LONG >= (1 << rsfr_pkg::SLOT_W) || SLOT_SHORT < 1 || SLOT_LONG < 1)
            $error("slot grid counts out of range");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 2;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_r;
    logic [NPIN-1:0] pin_sync_r;
    assign pin_raw = {direct_tx_bit, chip_en};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                end else if (ce) begin
                    pin_meta_r[gi] <= pin_raw[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    logic en_sync;
    logic dir_sync;
    logic srst;
    logic run;
    assign en_sync = pin_sync_r[0];
    assign dir_sync = pin_sync_r[1];
    assign srst = !aresetn || !en_sync;
    assign run = ce && !srst;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic rsfr_pkg::rsfr_sel_e reg_sel(input logic [rsfr_pkg::ADDR_W-1:0] a);
        case (a)
            rsfr_pkg::ADDR_OPT: reg_sel = rsfr_pkg::RSFR_SEL_OPT;
            rsfr_pkg::ADDR_MIRROR: reg_sel = rsfr_pkg::RSFR_SEL_MIRROR;
            rsfr_pkg::ADDR_FIFO: reg_sel = rsfr_pkg::RSFR_SEL_FIFO;
            default: reg_sel = rsfr_pkg::RSFR_SEL_NONE;
        endcase
    endfunction

    function automatic logic is_select_code(input logic [7:0] b);
        is_select_code = b == rsfr_pkg::SEL_CL1 || b == rsfr_pkg::SEL_CL2
            || b == rsfr_pkg::SEL_CL3;
    endfunction

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic [rsfr_pkg::ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic [7:0] opt_r;
    logic [7:0] fifo_thr_r;
    logic wr_go;
    rsfr_pkg::rsfr_sel_e wr_sel;
    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_sel = reg_sel(aw_addr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rsfr_pkg::RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata[7:0];
                w_strb_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == rsfr_pkg::RSFR_SEL_NONE) ? rsfr_pkg::RESP_SLVERR
                    : rsfr_pkg::RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // option and threshold registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (srst) begin
            opt_r <= rsfr_pkg::OPT_RESET;
            fifo_thr_r <= rsfr_pkg::FIFO_RESET;
        end else if (ce && wr_go && w_strb_r) begin
            if (wr_sel == rsfr_pkg::RSFR_SEL_OPT)
                opt_r <= w_data_r & rsfr_pkg::OPT_WMASK;
            if (wr_sel == rsfr_pkg::RSFR_SEL_FIFO)
                fifo_thr_r <= w_data_r & rsfr_pkg::FIFO_WMASK;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        case (reg_sel(s_axi_araddr))
            rsfr_pkg::RSFR_SEL_OPT: rd_byte = opt_r;
            rsfr_pkg::RSFR_SEL_MIRROR: rd_byte = 8'(rx_start_r) << rsfr_pkg::MIRROR_RXS;
            rsfr_pkg::RSFR_SEL_FIFO: rd_byte = fifo_thr_r;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rsfr_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= (reg_sel(s_axi_araddr) == rsfr_pkg::RSFR_SEL_NONE)
                    ? rsfr_pkg::RESP_SLVERR : rsfr_pkg::RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // receive-side options
    // ------------------------------------------------------------
    logic [2:0] col_cnt_r;
    logic [2:0] col_thr;
    assign col_thr = opt_r[rsfr_pkg::OPT_COL] ? rsfr_pkg::COL_PULSES_SHORT
        : rsfr_pkg::COL_PULSES_LONG;

    always_ff @(posedge aclk) begin
        if (srst) begin
            parity_err_r <= 1'b0;
            short_frame_ok_r <= 1'b0;
        end else if (ce) begin
            parity_err_r <= parity_err_raw && !opt_r[rsfr_pkg::OPT_PAR_DIS];
            short_frame_ok_r <= rx_nibble_end && opt_r[rsfr_pkg::OPT_SHORT_RX];
        end
    end

    // saturating pulse counter, restarted per bit window
    always_ff @(posedge aclk) begin
        if (srst) begin
            col_cnt_r <= 3'h0;
            collision_err_r <= 1'b0;
        end else if (ce) begin
            collision_err_r <= 1'b0;
            if (coll_window_start) begin
                col_cnt_r <= 3'h0;
            end else if (subcarrier_pulse && rx_active && col_cnt_r != col_thr) begin
                col_cnt_r <= col_cnt_r + 3'h1;
                collision_err_r <= (col_cnt_r + 3'h1) == col_thr;
            end
        end
    end

    // ------------------------------------------------------------
    // receive-start flag
    // ------------------------------------------------------------
    rsfr_pkg::rsfr_rx_e rx_state_r;
    always_ff @(posedge aclk) begin
        if (srst) begin
            rx_state_r <= rsfr_pkg::RSFR_RX_IDLE;
            rx_start_r <= 1'b0;
            rx_done_irq_r <= 1'b0;
        end else if (ce) begin
            rx_done_irq_r <= 1'b0;
            case (rx_state_r)
                rsfr_pkg::RSFR_RX_IDLE: begin
                    if (rx_sof_seen) begin
                        rx_state_r <= rsfr_pkg::RSFR_RX_BUSY;
                        rx_start_r <= 1'b1;
                    end
                end
                rsfr_pkg::RSFR_RX_BUSY: begin
                    if (rx_done) begin
                        rx_state_r <= rsfr_pkg::RSFR_RX_IDLE;
                        rx_start_r <= 1'b0;
                        rx_done_irq_r <= 1'b1;
                    end
                end
                default: begin
                    rx_state_r <= rsfr_pkg::RSFR_RX_IDLE;
                    rx_start_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // transmit-side options
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (srst) begin
            enc_bit_r <= 1'b0;
            enc_valid_r <= 1'b0;
            fifo_tx_pop_r <= 1'b0;
            anticoll_broken_r <= 1'b0;
            slot_step_cyc_r <= rsfr_pkg::SLOT_W'(SLOT_SHORT);
        end else if (ce) begin
            enc_valid_r <= bit_tick;
            fifo_tx_pop_r <= bit_tick && !opt_r[rsfr_pkg::OPT_DIRECT];
            if (bit_tick)
                enc_bit_r <= opt_r[rsfr_pkg::OPT_DIRECT] ? dir_sync : fifo_tx_bit;
            if (tx_byte_first)
                anticoll_broken_r <= !opt_r[rsfr_pkg::OPT_FRAMING]
                    && is_select_code(tx_byte);
            slot_step_cyc_r <= opt_r[rsfr_pkg::OPT_SLOT] ? rsfr_pkg::SLOT_W'(SLOT_LONG)
                : rsfr_pkg::SLOT_W'(SLOT_SHORT);
        end
    end

    rsfr_fifo_level #(
        .CNT_W(CNT_W)
    ) u_level (
        .aclk(aclk),
        .srst(srst),
        .ce(ce),
        .hi_code(fifo_thr_r[rsfr_pkg::FIFO_HI_LSB +: 2]),
        .lo_code(fifo_thr_r[rsfr_pkg::FIFO_LO_LSB +: 2]),
        .fifo_count(fifo_count),
        .rx_active(rx_active),
        .tx_active(tx_active),
        .fifo_high_r(fifo_high_irq_r),
        .fifo_low_r(fifo_low_irq_r)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_parity_masked: assert property (@(posedge aclk) disable iff (srst)
        run && parity_err_raw && opt_r[rsfr_pkg::OPT_PAR_DIS] |=> !parity_err_r)
        else $error("parity error reported while disabled");
    chk_parity_passed: assert property (@(posedge aclk) disable iff (srst)
        run && parity_err_raw && !opt_r[rsfr_pkg::OPT_PAR_DIS] |=> parity_err_r)
        else $error("parity error lost");
    chk_slot_step: assert property (@(posedge aclk) disable iff (srst)
        run ##1 run |=> slot_step_cyc_r == ($past(opt_r[rsfr_pkg::OPT_SLOT], 1)
            ? rsfr_pkg::SLOT_W'(SLOT_LONG) : rsfr_pkg::SLOT_W'(SLOT_SHORT)))
        else $error("slot step does not follow grid bit");
    chk_direct_path: assert property (@(posedge aclk) disable iff (srst)
        run && bit_tick && opt_r[rsfr_pkg::OPT_DIRECT]
        |=> enc_valid_r && !fifo_tx_pop_r && enc_bit_r == $past(dir_sync))
        else $error("direct bit stream not routed to encoder");
    chk_short_rx: assert property (@(posedge aclk) disable iff (srst)
        short_frame_ok_r |-> $past(opt_r[rsfr_pkg::OPT_SHORT_RX]))
        else $error("nibble reply accepted in normal mode");
    chk_broken_bytes: assert property (@(posedge aclk) disable iff (srst)
        anticoll_broken_r |-> !$past(opt_r[rsfr_pkg::OPT_FRAMING], 1)
            || !$past(tx_byte_first) || !$past(ce))
        else $error("broken bytes with normal framing");
    chk_collision_count: assert property (@(posedge aclk) disable iff (srst)
        collision_err_r |-> $past(col_cnt_r) + 3'h1 == $past(col_thr))
        else $error("collision raised at wrong pulse count");
    chk_mirror_read: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && s_axi_arvalid && s_axi_arready
            && reg_sel(s_axi_araddr) == rsfr_pkg::RSFR_SEL_MIRROR
        |=> s_axi_rvalid && s_axi_rdata[0] == $past(rx_start_r))
        else $error("mirror bit differs from receive-start flag");
    chk_rx_start_hold: assert property (@(posedge aclk) disable iff (srst)
        run && rx_start_r && !rx_done |=> rx_start_r)
        else $error("receive-start dropped during reception");
    chk_rx_done_irq: assert property (@(posedge aclk) disable iff (srst)
        run && rx_start_r && rx_done |=> rx_done_irq_r && !rx_start_r)
        else $error("no completion interrupt");
    chk_enable_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        !en_sync |=> opt_r == 8'h00 && fifo_thr_r == 8'h00)
        else $error("registers not cleared with chip disabled");
    chk_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0 && opt_r[7:6] == 2'h0)
        else $error("reserved bits not zero");

    cov_write_opt: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_sel == rsfr_pkg::RSFR_SEL_OPT);
    cov_read_mirror: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rdata[0]);
    cov_collision: cover property (@(posedge aclk) disable iff (srst) collision_err_r);
    cov_rx_irq: cover property (@(posedge aclk) disable iff (srst) rx_done_irq_r);
endmodule

//--- tb/rsfr_host_model.sv
// axi4-lite host model issuing one register access at a time
`timescale 1ns/1ps
module rsfr_host_model (
    input wire logic aclk,
    output logic [9:0] s_axi_awaddr = 10'h000,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [9:0] s_axi_araddr = 10'h000,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    logic hung = 1'b0;
    task automatic acc(input logic we, input logic [9:0] a, input logic [31:0] v,
                       output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_bready <= we;
        s_axi_arvalid <= !we;
        s_axi_rready <= !we;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid || s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = we ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        // released data no longer shows the last value
        s_axi_wdata <= ~v;
        s_axi_awaddr <= ~a;
        s_axi_araddr <= ~a;
        hung = hung | (n == 50);
    endtask
endmodule

//--- tb/rsfr_regs_tb_top.sv
// self-checking bench for the special-function register block
`timescale 1ns/1ps
module rsfr_regs_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic chip_en = 1'b1;
    logic rx_active = 1'b1;
    logic tx_active = 1'b1;
    logic [7:0] fifo_count = 8'h00;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] st = 8'h00;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, parity_err_r, fifo_tx_pop_r;
    logic short_frame_ok_r, anticoll_broken_r, collision_err_r, rx_start_r, rx_done_irq_r;
    logic fifo_high_irq_r, fifo_low_irq_r, enc_bit_r, enc_valid_r;
    logic dbit = 1'b0;
    logic [13:0] slot_step_cyc_r;
    int n_fail = 0;
    int num_checks = 0;
    always #2 aclk = ~aclk;
    rsfr_host_model host_u (.*);
    rsfr_regs dut_u (.*, .ce(1'b1), .s_axi_wstrb(4'hF), .rx_sof_seen(st[0]), .rx_done(st[1]),
        .parity_err_raw(st[2]), .coll_window_start(st[3]), .subcarrier_pulse(st[4]),
        .rx_nibble_end(st[5]), .tx_byte_first(st[6]), .bit_tick(st[7]), .fifo_tx_bit(1'b0),
        .direct_tx_bit(dbit));
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ax(input logic we, input logic [9:0] a, input logic [31:0] v,
                      input logic [1:0] er = rsfr_pkg::RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        host_u.acc(we, a, v, d, r);
        if (host_u.hung) final_report();
        ck("resp", er, r);
        if (!we) ck("rdata", v, d);
    endtask
    task automatic pulse(input int b);
        @(posedge aclk);
        st[b] <= 1'b1;
        @(posedge aclk);
        st[b] <= 1'b0;
        #1;
    endtask
    task automatic t_reset;
        ax(1'b0, rsfr_pkg::ADDR_OPT, 32'h0);
        ax(1'b0, rsfr_pkg::ADDR_MIRROR, 32'h0);
        ax(1'b0, rsfr_pkg::ADDR_FIFO, 32'h0);
        ck("slot", 14'h1270, slot_step_cyc_r);
        $display("reset test done");
    endtask
    task automatic t_opt;
        int i;
        int j;
        logic [7:0] sel [4];
        sel = '{8'h93, 8'h95, 8'h97, 8'h92};
        dbit <= 1'b1;
        for (i = 1; i >= 0; i--) begin
            ax(1'b1, rsfr_pkg::ADDR_OPT, i ? 32'h0 : 32'hFFFF_FFFF);
            ax(1'b0, rsfr_pkg::ADDR_OPT, i ? 32'h0 : 32'h3F);
            ck("slot", i ? 14'h1270 : 14'h24E2, slot_step_cyc_r);
            pulse(2);
            ck("parity", i, parity_err_r);
            pulse(5);
            ck("short", !i, short_frame_ok_r);
            pulse(7);
            ck("pop", i, fifo_tx_pop_r);
            ck("enc_bit", !i, enc_bit_r);
            ck("enc_valid", 1, enc_valid_r);
            pulse(3);
            for (j = 1; j <= 7; j++) begin
                pulse(4);
                ck("coll", j == (i ? 7 : 6), collision_err_r);
            end
            for (j = 0; j < 4; j++) begin
                @(posedge aclk);
                tx_byte <= sel[j];
                pulse(6);
                ck("broken", i && j < 3, anticoll_broken_r);
            end
        end
        $display("option test done");
    endtask
    task automatic t_rx;
        pulse(0);
        ax(1'b0, rsfr_pkg::ADDR_MIRROR, 32'h1);
        ax(1'b1, rsfr_pkg::ADDR_MIRROR, 32'h0);
        ck("rx_start", 1, rx_start_r);
        pulse(1);
        ck("rx_start", 0, rx_start_r);
        ck("done_irq", 1, rx_done_irq_r);
        ax(1'b0, rsfr_pkg::ADDR_MIRROR, 32'h0);
        ax(1'b1, 10'h3FC, 32'h5, rsfr_pkg::RESP_SLVERR);
        ax(1'b0, 10'h3FC, 32'h0, rsfr_pkg::RESP_SLVERR);
        $display("receive test done");
    endtask
    task automatic t_fifo;
        int hl [4] = '{124, 120, 112, 96};
        int ll [4] = '{4, 8, 16, 32};
        int i;
        int k;
        for (i = 0; i < 4; i++) begin
            ax(1'b1, rsfr_pkg::ADDR_FIFO, 32'hF0 | 32'(i * 5));
            ax(1'b0, rsfr_pkg::ADDR_FIFO, 32'(i * 5));
            for (k = 0; k < 4; k++) begin
                @(posedge aclk);
                fifo_count <= 8'(k < 2 ? hl[i] - k : ll[i] + k - 2);
                repeat (2) @(posedge aclk);
                #1;
                ck("high", k == 0, fifo_high_irq_r);
                ck("low", k == 2, fifo_low_irq_r);
            end
        end
        @(posedge aclk);
        rx_active <= 1'b0;
        fifo_count <= 8'h7F;
        repeat (2) @(posedge aclk);
        #1;
        ck("high_idle", 0, fifo_high_irq_r);
        $display("fifo test done");
    endtask
    task automatic t_en;
        ax(1'b1, rsfr_pkg::ADDR_OPT, 32'h3F);
        chip_en <= 1'b0;
        repeat (4) @(posedge aclk);
        chip_en <= 1'b1;
        repeat (4) @(posedge aclk);
        t_reset();
        $display("enable test done");
    endtask
    task automatic final_report;
        if (host_u.hung) n_fail++;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_reset();
        t_opt();
        t_rx();
        t_fifo();
        t_en();
        final_report();
    end
endmodule
